// [rtl/sbt_pkg.sv]
// Purpose: Shared constants and types for the sixteen-bit timer control block.
// Assumes: Byte-wide register port, 250 MHz core clock.
// Notes:   Register offsets follow the timer's own byte map.
package sbt_pkg;
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 8;
	localparam int          CNT_W         = 16;
	// Register offsets (low nibble of the byte map)
	localparam logic [3:0]  OFS_CTRL_TWO  = 4'h1;
	localparam logic [3:0]  OFS_CTRL_ONE  = 4'h2;
	localparam logic [3:0]  OFS_STATUS    = 4'h3;
	localparam logic [3:0]  OFS_CAP1_HI   = 4'h4;
	localparam logic [3:0]  OFS_CAP1_LO   = 4'h5;
	localparam logic [3:0]  OFS_CMP1_HI   = 4'h6;
	localparam logic [3:0]  OFS_CMP1_LO   = 4'h7;
	localparam logic [3:0]  OFS_CNT_HI    = 4'h8;
	localparam logic [3:0]  OFS_CNT_LO    = 4'h9;
	localparam logic [3:0]  OFS_ACNT_HI   = 4'hA;
	localparam logic [3:0]  OFS_ACNT_LO   = 4'hB;
	localparam logic [3:0]  OFS_CAP2_HI   = 4'hC;
	localparam logic [3:0]  OFS_CAP2_LO   = 4'hD;
	localparam logic [3:0]  OFS_CMP2_HI   = 4'hE;
	localparam logic [3:0]  OFS_CMP2_LO   = 4'hF;
	// Reset values
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [15:0] CNT_RST       = 16'hFFFC;
	localparam logic [15:0] CMP_RST       = 16'h8000;
	localparam logic [15:0] CNT_MAX       = 16'hFFFF;
	localparam logic [15:0] PWM_RELOAD    = 16'hFFFC;
	// Status bit positions
	localparam int          ST_CAP1       = 7;
	localparam int          ST_CMP1       = 6;
	localparam int          ST_OVF        = 5;
	localparam int          ST_CAP2       = 4;
	localparam int          ST_CMP2       = 3;
	localparam int          ST_DIS        = 2;
	// Clock select codes
	localparam logic [1:0]  CLK_DIV4      = 2'h0;
	localparam logic [1:0]  CLK_DIV2      = 2'h1;
	localparam logic [1:0]  CLK_DIV8      = 2'h2;
	localparam logic [1:0]  CLK_EXT       = 2'h3;
	localparam logic [2:0]  PRE_MASK2     = 3'h1;
	localparam logic [2:0]  PRE_MASK4     = 3'h3;
	localparam logic [2:0]  PRE_MASK8     = 3'h7;

	// First control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic captureIrqEnable;
		logic compareIrqEnable;
		logic overflowIrqEnable;
		logic forceOutputTwo;
		logic forceOutputOne;
		logic outputLevelTwo;
		logic captureEdgeOne;
		logic outputLevelOne;
	} sbt_ctrl_one_t;

	// Second control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       comparePinOneEnable;
		logic       comparePinTwoEnable;
		logic       onePulseSelect;
		logic       pulseWidthSelect;
		logic [1:0] clockSelectField;
		logic       captureEdgeTwo;
		logic       extClockEdge;
	} sbt_ctrl_two_t;

	// Compare pin outputs
	typedef struct packed {
		logic pinOne;
		logic pinOneEn;
		logic pinTwo;
		logic pinTwoEn;
	} sbt_cmp_pins_t;
endpackage

// [rtl/sbt_timer.sv]
// Purpose: Control, status and event logic of a 16-bit free-running timer.
// Assumes: Pins are synchronous to clk; software strobes are single-cycle.
// Notes:   Flag clears take a status read then a low-byte access.
//
// Function
// RQ1: All five events share one interrupt line, gated by enables and global mask.
// RQ2: Capture enable lets either capture flag request an interrupt.
// RQ3: Compare enable lets either compare flag request an interrupt.
// RQ4: Overflow enable lets the overflow flag request an interrupt.
// RQ5: Force bits copy output levels to enabled pins without a match.
// RQ6: Compare-two match drives level two; in pulse modes onto pin one. One-pulse mode drives level two onto pin one at the capture-one edge instead.
// RQ7: Capture one triggers on rising edge if edge bit set, else falling.
// RQ8: Compare-one match copies level one to enabled pin one.
// RQ9: Pin enables only connect outputs; compare logic runs regardless.
// RQ10: One-pulse mode starts a pulse on capture-one edge; compare one ends it.
// RQ11: Pulse-width mode: compare one sets pulse, compare two sets period.
// RQ12: Clock field selects divide by 4, 2, 8 or external clock.
// RQ13: Without an external clock pin, external selection halts the counter.
// RQ14: Capture two triggers on rising edge if edge bit set, else falling.
// RQ15: External clock edge bit picks rising or falling counting edge.
// RQ16: Capture flag one sets on capture or pulse-width period end; cleared by sequence.
// RQ17: Compare flag one sets on match; cleared by status read then low access.
// RQ18: Overflow flag sets on wrap; only counter low access clears it.
// RQ19: Capture flag two sets on capture two; cleared by sequence.
// RQ20: Compare flag two sets on match; cleared by sequence.
// RQ21: Disable bit freezes prescaler, counter and compare pin outputs.
// RQ22: Events may wake from wait only; compare events absent in pulse-width mode.
// RQ23: Software reads status while the flag is set before the clearing access.
// RQ24: Writing counter low or alternate counter low resets the counter.
// RQ25: A flag event coinciding with its clearing access keeps the flag set.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
module sbt_timer
	import sbt_pkg::*;
#(
	parameter bit HAS_EXT_CLOCK = 1'b1
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Register port
	input  wire logic [ADDR_W-1:0]   regAddr,
	input  wire logic [DATA_W-1:0]   regWrData,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	output logic      [DATA_W-1:0]   regRdData,
	// Processor side
	input  wire logic                globalIrqMask,
	output logic                     timerIrq,
	output logic                     waitWakeup,
	// Timer pins
	input  wire logic                capturePinOne,
	input  wire logic                capturePinTwo,
	input  wire logic                extClockPin,
	output sbt_cmp_pins_t            comparePins
);

	sbt_ctrl_one_t     ctrlOne_r;
	sbt_ctrl_two_t     ctrlTwo_r;
	logic              disable_r;
	logic [4:0]        flags_r;
	logic [4:0]        flagsSeen_r;
	logic [CNT_W-1:0]  count_r;
	logic [CNT_W-1:0]  cmpOne_r;
	logic [CNT_W-1:0]  cmpTwo_r;
	logic [CNT_W-1:0]  cmpOneAct_r;
	logic [CNT_W-1:0]  cmpTwoAct_r;
	logic [CNT_W-1:0]  capOne_r;
	logic [CNT_W-1:0]  capTwo_r;
	logic [2:0]        presc_r;
	logic              capOnePrev_r;
	logic              capTwoPrev_r;
	logic              extPrev_r;
	logic              pinOneLvl_r;
	logic              pinTwoLvl_r;
	logic              cmpOneArmed_r;
	logic              cmpTwoArmed_r;
	logic              pulseActive_r;
	logic [DATA_W-1:0] rdData_nxt;

	logic pwmMode;
	logic opmMode;
	logic tick;
	logic capOneEdge;
	logic capTwoEdge;
	logic cmpOneHit;
	logic cmpTwoHit;
	logic wrap;
	logic cntWrite;
	logic [4:0] flagSet;
	logic [4:0] flagClr;
	logic [2:0] prescMask;

	// Active-edge test shared by both capture inputs and the external clock
	function automatic logic edgeSeen(input logic prev, input logic now, input logic rising);
		edgeSeen = rising ? (!prev && now) : (prev && !now);
	endfunction

	// Low-byte access test used by the flag clear sequence
	function automatic logic lowAccess(input logic [ADDR_W-1:0] ofs);
		lowAccess = (regRead || regWrite) && regAddr == ofs;
	endfunction

	// Mode decode; pulse-width wins over one-pulse
	assign pwmMode = ctrlTwo_r.pulseWidthSelect;
	assign opmMode = ctrlTwo_r.onePulseSelect && !pwmMode;

	// Input sampling for edge detection
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			capOnePrev_r <= 1'b0;
			capTwoPrev_r <= 1'b0;
			extPrev_r    <= 1'b0;
		end else begin
			capOnePrev_r <= capturePinOne;
			capTwoPrev_r <= capturePinTwo;
			extPrev_r    <= extClockPin;
		end
	end

	assign capOneEdge = edgeSeen(capOnePrev_r, capturePinOne, ctrlOne_r.captureEdgeOne); // see RQ7
	assign capTwoEdge = edgeSeen(capTwoPrev_r, capturePinTwo, ctrlTwo_r.captureEdgeTwo); // see RQ14

	// Prescaler mask per clock selection
	always_comb begin
		case (ctrlTwo_r.clockSelectField) // see RQ12
			CLK_DIV2: prescMask = PRE_MASK2;
			CLK_DIV8: prescMask = PRE_MASK8;
			default:  prescMask = PRE_MASK4;
		endcase
	end

	// Counter tick source
	always_comb begin
		if (disable_r) begin
			tick = 1'b0; // see RQ21
		end else if (ctrlTwo_r.clockSelectField == CLK_EXT) begin
			tick = HAS_EXT_CLOCK && edgeSeen(extPrev_r, extClockPin, ctrlTwo_r.extClockEdge); // see RQ13, RQ15
		end else begin
			tick = (presc_r & prescMask) == prescMask;
		end
	end

	// Prescaler, frozen while disabled
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			presc_r <= 3'h0;
		end else if (!disable_r) begin
			presc_r <= presc_r + 3'h1; // see RQ21
		end
	end

	// A compare stays inhibited between its high and low byte writes
	assign cmpOneHit = tick && cmpOneArmed_r && count_r == cmpOneAct_r;
	assign cmpTwoHit = tick && cmpTwoArmed_r && count_r == cmpTwoAct_r;
	assign wrap      = tick && count_r == CNT_MAX && !(pwmMode && cmpTwoHit);
	assign cntWrite  = regWrite && (regAddr == OFS_CNT_LO || regAddr == OFS_ACNT_LO);

	// Free-running counter with reload on write and at pulse-width period end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_r <= CNT_RST;
		end else if (cntWrite) begin
			count_r <= CNT_RST; // see RQ24
		end else if (pwmMode && cmpTwoHit) begin
			count_r <= PWM_RELOAD; // see RQ11
		end else if (opmMode && capOneEdge) begin
			count_r <= PWM_RELOAD; // see RQ10
		end else if (tick) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// Compare registers; the high write inhibits compare until the low write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmpOne_r      <= CMP_RST;
			cmpTwo_r      <= CMP_RST;
			cmpOneArmed_r <= 1'b1;
			cmpTwoArmed_r <= 1'b1;
		end else if (regWrite) begin
			case (regAddr)
				OFS_CMP1_HI: begin
					cmpOne_r[15:8] <= regWrData;
					cmpOneArmed_r  <= 1'b0;
				end
				OFS_CMP1_LO: begin
					cmpOne_r[7:0]  <= regWrData;
					cmpOneArmed_r  <= 1'b1;
				end
				OFS_CMP2_HI: begin
					cmpTwo_r[15:8] <= regWrData;
					cmpTwoArmed_r  <= 1'b0;
				end
				OFS_CMP2_LO: begin
					cmpTwo_r[7:0]  <= regWrData;
					cmpTwoArmed_r  <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// Active compare values; double-buffered at period end in pulse-width mode
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmpOneAct_r <= CMP_RST;
			cmpTwoAct_r <= CMP_RST;
		end else if (!pwmMode || cmpTwoHit) begin
			cmpOneAct_r <= cmpOne_r;
			cmpTwoAct_r <= cmpTwo_r;
		end
	end

	// Captures; pin one is not a capture source in pulse modes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			capOne_r <= 16'h0000;
			capTwo_r <= 16'h0000;
		end else begin
			if (capOneEdge && !pwmMode && !opmMode) begin
				capOne_r <= count_r;
			end
			if (capTwoEdge) begin
				capTwo_r <= count_r;
			end
		end
	end

	// Flag set events, in status bit order capture1, compare1, overflow, capture2, compare2
	assign flagSet[4] = (capOneEdge && !pwmMode && !opmMode) || (pwmMode && cmpTwoHit); // see RQ16
	assign flagSet[3] = cmpOneHit && cmpOneArmed_r && !pwmMode && !opmMode; // see RQ17, RQ22
	assign flagSet[2] = wrap; // see RQ18
	assign flagSet[1] = capTwoEdge; // see RQ19
	assign flagSet[0] = cmpTwoHit && cmpTwoArmed_r && !pwmMode; // see RQ20, RQ22

	// Clearing access to each flag's low byte; alternate counter excluded
	assign flagClr[4] = flagsSeen_r[4] && lowAccess(OFS_CAP1_LO); // see RQ16
	assign flagClr[3] = flagsSeen_r[3] && lowAccess(OFS_CMP1_LO); // see RQ17
	assign flagClr[2] = flagsSeen_r[2] && lowAccess(OFS_CNT_LO); // see RQ18
	assign flagClr[1] = flagsSeen_r[1] && lowAccess(OFS_CAP2_LO); // see RQ19
	assign flagClr[0] = flagsSeen_r[0] && lowAccess(OFS_CMP2_LO); // see RQ20

	// Event flags; a set in the clearing cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : gFlag
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					flags_r[gi]     <= 1'b0;
					flagsSeen_r[gi] <= 1'b0;
				end else begin
					flags_r[gi] <= flagSet[gi] | (flags_r[gi] & ~flagClr[gi]); // see RQ25
					if (regRead && regAddr == OFS_STATUS) begin
						flagsSeen_r[gi] <= flags_r[gi]; // see RQ23
					end else if (flagClr[gi]) begin
						flagsSeen_r[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Control registers and disable bit
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrlOne_r <= CTRL_RST;
			ctrlTwo_r <= CTRL_RST;
			disable_r <= 1'b0;
		end else if (regWrite) begin
			case (regAddr)
				OFS_CTRL_ONE: ctrlOne_r <= regWrData;
				OFS_CTRL_TWO: ctrlTwo_r <= regWrData;
				OFS_STATUS:   disable_r <= regWrData[ST_DIS]; // see RQ21
				default: ;
			endcase
		end
	end

	// One-pulse activity tracking
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pulseActive_r <= 1'b0;
		end else if (!opmMode) begin
			pulseActive_r <= 1'b0;
		end else if (capOneEdge) begin
			pulseActive_r <= 1'b1; // see RQ10
		end else if (cmpOneHit) begin
			pulseActive_r <= 1'b0;
		end
	end

	// Compare output levels; forced writes act without a match
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pinOneLvl_r <= 1'b0;
			pinTwoLvl_r <= 1'b0;
		end else if (pwmMode) begin
			if (cmpTwoHit) begin
				pinOneLvl_r <= ctrlOne_r.outputLevelTwo; // see RQ6, RQ11
			end else if (cmpOneHit) begin
				pinOneLvl_r <= ctrlOne_r.outputLevelOne; // see RQ11
			end
		end else if (opmMode) begin
			if (capOneEdge) begin
				pinOneLvl_r <= ctrlOne_r.outputLevelTwo; // see RQ6, RQ10
			end else if (pulseActive_r && cmpOneHit) begin
				pinOneLvl_r <= ctrlOne_r.outputLevelOne; // see RQ10
			end
		end else begin
			if (cmpOneHit || ctrlOne_r.forceOutputOne) begin
				pinOneLvl_r <= ctrlOne_r.outputLevelOne; // see RQ8, RQ5
			end
			if (cmpTwoHit || ctrlOne_r.forceOutputTwo) begin
				pinTwoLvl_r <= ctrlOne_r.outputLevelTwo; // see RQ6, RQ5
			end
		end
	end

	// Pin drive; enables only connect the pins, disable blocks both
	always_comb begin
		comparePins.pinOne   = pinOneLvl_r;
		comparePins.pinTwo   = pinTwoLvl_r;
		comparePins.pinOneEn = ctrlTwo_r.comparePinOneEnable && !disable_r; // see RQ9, RQ21
		comparePins.pinTwoEn = ctrlTwo_r.comparePinTwoEnable && !disable_r && !opmMode && !pwmMode; // see RQ9
	end

	// Shared interrupt request
	always_comb begin
		waitWakeup = (ctrlOne_r.captureIrqEnable  && (flags_r[4] || flags_r[1])) // see RQ2
		          || (ctrlOne_r.compareIrqEnable  && (flags_r[3] || flags_r[0])) // see RQ3
		          || (ctrlOne_r.overflowIrqEnable && flags_r[2]); // see RQ4
		timerIrq   = waitWakeup && !globalIrqMask; // see RQ1, RQ22
	end

	// Read mux
	always_comb begin
		case (regAddr)
			OFS_CTRL_ONE: rdData_nxt = ctrlOne_r;
			OFS_CTRL_TWO: rdData_nxt = ctrlTwo_r;
			OFS_STATUS:   rdData_nxt = {flags_r, disable_r, 2'b00};
			OFS_CAP1_HI:  rdData_nxt = capOne_r[15:8];
			OFS_CAP1_LO:  rdData_nxt = capOne_r[7:0];
			OFS_CMP1_HI:  rdData_nxt = cmpOne_r[15:8];
			OFS_CMP1_LO:  rdData_nxt = cmpOne_r[7:0];
			OFS_CNT_HI,
			OFS_ACNT_HI:  rdData_nxt = count_r[15:8];
			OFS_CNT_LO,
			OFS_ACNT_LO:  rdData_nxt = count_r[7:0];
			OFS_CAP2_HI:  rdData_nxt = capTwo_r[15:8];
			OFS_CAP2_LO:  rdData_nxt = capTwo_r[7:0];
			OFS_CMP2_HI:  rdData_nxt = cmpTwo_r[15:8];
			OFS_CMP2_LO:  rdData_nxt = cmpTwo_r[7:0];
			default:      rdData_nxt = 8'h00;
		endcase
	end

	// Read data register, valid the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			regRdData <= rdData_nxt;
		end else begin
			regRdData <= 8'h00;
		end
	end
endmodule

// [tb/sbt_pin_model.sv]
// Purpose: Far-side pins: capture inputs and the external clock source.
// Assumes: Levels change just after a rising clk edge.
// Notes:   The external clock stands low-or-held between bursts.
`timescale 1ns/1ns
module sbt_pin_model (
	// Clock
	input wire logic clk,
	// Pins toward the timer
	output logic     capOne,
	output logic     capTwo,
	output logic     ext_clock_pin
);
	// Quiet levels at time zero
	initial begin
		capOne = 1'b0;
		capTwo = 1'b0;
		ext_clock_pin = 1'b0;
	end
	// Drive one capture input to a level
	task automatic setCap(input bit which, input logic lvl);
		@(posedge clk);
		if (which) begin
			capTwo <= lvl;
		end else begin
			capOne <= lvl;
		end
	endtask
	// Toggle the external clock n times, half cycles apart
	task automatic runExt(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge clk);
			ext_clock_pin <= ~ext_clock_pin;
		end
	endtask
endmodule

// [tb/sbt_timer_monitor.sv]
// Purpose: Concurrent checks on the timer control block ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Interrupt enables and the disable bit are shadowed from writes.
`timescale 1ns/1ns
module sbt_timer_monitor
	import sbt_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              reset_n,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [DATA_W-1:0] regRdData,
	// Processor side
	input wire logic              globalIrqMask,
	input wire logic              timerIrq,
	input wire logic              waitWakeup,
	// Timer pins
	input wire logic              capturePinOne,
	input wire logic              capturePinTwo,
	input wire logic              extClockPin,
	input wire sbt_cmp_pins_t     comparePins
);
	logic [2:0] irqEn_r;
	logic       dis_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Shadow copies of enables and disable bit
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irqEn_r <= 3'h0;
			dis_r <= 1'b0;
		end else if (regWrite && regAddr == OFS_CTRL_ONE) begin
			irqEn_r <= regWrData[7:5];
		end else if (regWrite && regAddr == OFS_STATUS) begin
			dis_r <= regWrData[ST_DIS];
		end
	end
	AST_IRQ_MASKED: assert property (globalIrqMask |-> !timerIrq)
		else $error("interrupt while masked");
	AST_IRQ_WAKE: assert property (timerIrq == (waitWakeup && !globalIrqMask))
		else $error("interrupt and wake request disagree");
	AST_IRQ_NEEDS_EN: assert property (timerIrq |-> irqEn_r != 3'h0)
		else $error("interrupt with all enables clear");
	AST_WAKE_NEEDS_EN: assert property (waitWakeup |-> irqEn_r != 3'h0)
		else $error("wake request with all enables clear");
	AST_PIN1_EN: assert property (regWrite && regAddr == OFS_CTRL_TWO && !dis_r |=>
		comparePins.pinOneEn == $past(regWrData[7])) else $error("pin one enable wrong");
	AST_PIN2_EN: assert property (regWrite && regAddr == OFS_CTRL_TWO && !dis_r |=>
		comparePins.pinTwoEn == $past(regWrData[6])) else $error("pin two enable wrong");
	AST_CNT_RESET: assert property (regWrite && regAddr == OFS_CNT_LO ##2 regRead && regAddr == OFS_CNT_HI
		|=> regRdData == 8'hFF) else $error("counter not reset by low write");
	AST_CTRL_BACK: assert property (regWrite && regAddr == OFS_CTRL_ONE ##1 !regWrite ##1
		regRead && regAddr == OFS_CTRL_ONE |=> regRdData == $past(regWrData, 3))
		else $error("control one readback wrong");
	AST_STATUS_RSVD: assert property (regRead && regAddr == OFS_STATUS |=> regRdData[1:0] == 2'h0)
		else $error("reserved status bits set");
	// Main scenarios
	COV_IRQ: cover property (timerIrq);
	COV_PIN: cover property ($rose(comparePins.pinOne));
	COV_STATUS: cover property (regRead && regAddr == OFS_STATUS);
endmodule

bind sbt_timer sbt_timer_monitor u_mon (.clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead,
	.regRdData, .globalIrqMask, .timerIrq, .waitWakeup, .capturePinOne, .capturePinTwo,
	.extClockPin, .comparePins);

// [tb/testbench.sv]
// Purpose: Directed scenarios for the timer control block.
// Assumes: Register strobes one cycle, read data one cycle later.
// Notes:   Expected reset values come from the package constants; the frozen-counter check uses an earlier read; other expected values are literals.
`timescale 1ns/1ns
module testbench
	import sbt_pkg::*;
;
	logic              clk;
	logic              reset_n;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic              regWrite;
	logic              regRead;
	logic [DATA_W-1:0] regRdData;
	logic              globalIrqMask;
	logic              timerIrq;
	logic              waitWakeup;
	logic              capOne;
	logic              capTwo;
	logic              ext_clock_pin;
	sbt_cmp_pins_t     comparePins;
	logic [DATA_W-1:0] rdVal;
	logic [DATA_W-1:0] first;
	int                n_fail;
	int                compares;
	sbt_timer uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .globalIrqMask(globalIrqMask),
		.timerIrq(timerIrq), .waitWakeup(waitWakeup), .capturePinOne(capOne), .capturePinTwo(capTwo),
		.extClockPin(ext_clock_pin), .comparePins(comparePins));
	sbt_pin_model pins (.clk(clk), .capOne(capOne), .capTwo(capTwo), .ext_clock_pin(ext_clock_pin));
	// Verdict and end of run
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Register bus cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rdVal = regRdData;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic testReset();
		rd(OFS_CTRL_ONE);
		chk("ctrl one", CTRL_RST, rdVal);
		rd(OFS_CTRL_TWO);
		chk("ctrl two", CTRL_RST, rdVal);
		rd(OFS_CMP1_HI);
		chk("cmp1 hi", CMP_RST[15:8], rdVal);
		$display("reset test done");
	endtask
	task automatic testOverflow();
		wr(OFS_CNT_LO, 8'h00);
		settle(40);
		rd(OFS_STATUS);
		chk("overflow flag", 8'h20, rdVal & 8'h20);
		chk("irq off", 8'h00, {7'h0, timerIrq});
		wr(OFS_CTRL_ONE, 8'h20);
		settle(1);
		chk("irq on", 8'h01, {7'h0, timerIrq});
		@(posedge clk);
		globalIrqMask <= 1'b1;
		settle(1);
		chk("irq masked", 8'h00, {7'h0, timerIrq});
		chk("wake", 8'h01, {7'h0, waitWakeup});
		@(posedge clk);
		globalIrqMask <= 1'b0;
		rd(OFS_STATUS);
		rd(OFS_ACNT_LO);
		rd(OFS_STATUS);
		chk("alt keeps flag", 8'h20, rdVal & 8'h20);
		rd(OFS_CNT_LO);
		rd(OFS_STATUS);
		chk("flag cleared", 8'h00, rdVal & 8'h20);
		wr(OFS_CTRL_ONE, 8'h00);
		$display("overflow test done");
	endtask
	task automatic testCompare();
		int k;
		wr(OFS_CTRL_ONE, 8'h41);
		wr(OFS_CTRL_TWO, {4'h8, CLK_DIV2, 2'h0});
		wr(OFS_CMP1_HI, 8'h00);
		wr(OFS_CMP1_LO, 8'h10);
		wr(OFS_CNT_LO, 8'h00);
		chk("pin before", 8'h00, {7'h0, comparePins.pinOne});
		k = 0;
		while (k < 200 && comparePins.pinOne !== 1'b1) begin
			settle(1);
			k++;
		end
		chk("pin after match", 8'h01, {7'h0, comparePins.pinOne});
		rd(OFS_STATUS);
		chk("compare flag", 8'h40, rdVal & 8'h40);
		chk("compare irq", 8'h01, {7'h0, timerIrq});
		wr(OFS_CMP1_LO, 8'h10);
		rd(OFS_STATUS);
		chk("compare cleared", 8'h00, rdVal & 8'h40);
		if (k == 200) begin
			report_and_stop();
		end
		$display("compare test done");
	endtask
	task automatic testForce();
		wr(OFS_CTRL_TWO, {4'hC, CLK_DIV4, 2'h0});
		wr(OFS_CTRL_ONE, 8'h1C);
		settle(3);
		chk("forced pins", 8'h07, {4'h0, comparePins});
		wr(OFS_CTRL_ONE, 8'h19);
		settle(3);
		chk("forced pins swap", 8'h0D, {4'h0, comparePins});
		wr(OFS_CTRL_TWO, 8'h00);
		settle(1);
		chk("enables off", 8'h00, {6'h0, comparePins.pinOneEn, comparePins.pinTwoEn});
		$display("force test done");
	endtask
	task automatic testCapture();
		wr(OFS_CTRL_ONE, 8'h82);
		pins.setCap(1'b1, 1'b1);
		pins.setCap(1'b0, 1'b1);
		settle(4);
		rd(OFS_STATUS);
		chk("capture one", 8'h80, rdVal & 8'h90);
		chk("capture irq", 8'h01, {7'h0, timerIrq});
		pins.setCap(1'b1, 1'b0);
		settle(4);
		rd(OFS_STATUS);
		chk("capture two", 8'h90, rdVal & 8'h90);
		rd(OFS_CAP2_LO);
		rd(OFS_STATUS);
		chk("clear two", 8'h80, rdVal & 8'h90);
		rd(OFS_CAP1_LO);
		rd(OFS_STATUS);
		chk("clear one", 8'h00, rdVal & 8'h90);
		chk("irq gone", 8'h00, {7'h0, timerIrq});
		wr(OFS_CTRL_ONE, 8'h00);
		$display("capture test done");
	endtask
	task automatic testClock();
		logic [7:0] expd [3] = '{8'h08, 8'h10, 8'h04};
		for (int c = 0; c < 3; c++) begin
			wr(OFS_CTRL_TWO, {4'h0, c[1:0], 2'h0});
			rd(OFS_CNT_LO);
			first = rdVal;
			repeat (30) @(posedge clk);
			rd(OFS_CNT_LO);
			chk("prescaled ticks", expd[c], rdVal - first);
		end
		for (int e = 1; e >= 0; e--) begin
			wr(OFS_CTRL_TWO, {4'h0, CLK_EXT, 1'b0, e[0]});
			rd(OFS_CNT_LO);
			first = rdVal;
			pins.runExt(5, 3 - 2 * e);
			settle(4);
			rd(OFS_CNT_LO);
			chk("external ticks", 8'h03, rdVal - first);
		end
		$display("clock test done");
	endtask
	// Bounded wait for compare pin one to reach a level; k counts cycles
	task automatic waitPin(input logic lvl, output int k);
		k = 0;
		while (comparePins.pinOne !== lvl && k < 300) begin
			settle(1);
			k++;
		end
		if (k >= 300) begin
			n_fail++;
			$display("BAD pin wait expected %h seen %h", lvl, comparePins.pinOne);
			report_and_stop();
		end
	endtask
	// Pulse-width waveform, then a single pulse triggered by capture one
	task automatic testPwm();
		int k;
		wr(OFS_CMP2_HI, 8'h00);
		wr(OFS_CMP2_LO, 8'h20);
		wr(OFS_CMP1_HI, 8'h00);
		wr(OFS_CMP1_LO, 8'h10);
		wr(OFS_CTRL_ONE, 8'h86);
		wr(OFS_CTRL_TWO, {4'h9, CLK_DIV2, 2'h0});
		wr(OFS_CNT_LO, 8'h00);
		waitPin(1'b0, k);
		waitPin(1'b1, k);
		waitPin(1'b0, k);
		chk("pwm high cycles", 8'h2A, k[7:0]);
		waitPin(1'b1, k);
		chk("pwm low cycles", 8'h20, k[7:0]);
		rd(OFS_STATUS);
		chk("pwm flags", 8'h80, rdVal & 8'hC8);
		chk("pwm irq", 8'h01, {7'h0, timerIrq});
		waitPin(1'b0, k);
		wr(OFS_CTRL_TWO, {4'hA, CLK_DIV2, 2'h0});
		pins.setCap(1'b0, 1'b0);
		pins.setCap(1'b0, 1'b1);
		waitPin(1'b1, k);
		waitPin(1'b0, k);
		chk("one pulse length", 8'h01, {7'h0, k == 41 || k == 42});
		wr(OFS_CTRL_TWO, 8'h00);
		wr(OFS_CTRL_ONE, 8'h00);
		$display("pwm test done");
	endtask
	task automatic testDisable();
		wr(OFS_CTRL_TWO, {4'h0, CLK_DIV2, 2'h0});
		wr(OFS_STATUS, 8'h04);
		rd(OFS_CNT_LO);
		first = rdVal;
		settle(20);
		rd(OFS_CNT_LO);
		chk("frozen counter", first, rdVal);
		rd(OFS_STATUS);
		chk("disable bit", 8'h04, rdVal & 8'h07);
		wr(OFS_CNT_LO, 8'h00);
		rd(OFS_CNT_HI);
		chk("reset high", CNT_RST[15:8], rdVal);
		rd(OFS_CNT_LO);
		chk("reset low", CNT_RST[7:0], rdVal);
		wr(OFS_STATUS, 8'h00);
		$display("disable test done");
	endtask
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Main sequence
	initial begin
		n_fail = 0;
		compares = 0;
		reset_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		globalIrqMask = 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		testReset();
		testOverflow();
		testCompare();
		testForce();
		testCapture();
		testClock();
		testPwm();
		testDisable();
		report_and_stop();
	end
endmodule
